/* logic/rwdt_pkg.sv */
// package: register map, field layout, codes and timing counts of the runaway watchdog
package rwdt_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_FLAG = 8'h08;

  // mode register field positions
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_PER_LSB = 4;
  localparam int MODE_PER_MSB = 6;
  localparam int MODE_RSV_BIT = 2;
  localparam int MODE_ACT_BIT = 1;
  localparam int MODE_ZERO_BIT = 0;

  // flag register field position
  localparam int FLAG_LOCK_BIT = 0;

  // reset values
  localparam logic RST_EN = 1'b1;
  localparam logic [2:0] RST_PER = 3'h0;
  localparam logic RST_ACT = 1'b1;
  localparam logic RST_RSV = 1'b0;
  localparam logic RST_ZERO = 1'b0;

  // command codes
  localparam logic [7:0] CODE_DISABLE = 8'hB1;
  localparam logic [7:0] CODE_CLEAR = 8'h4E;

  // period select: exponent of code 000, step per code, highest legal code
  localparam int unsigned PER_EXP_BASE = 15;
  localparam logic [5:0] PER_EXP_STEP = 6'h02;
  localparam logic [2:0] PER_MAX_CODE = 3'h5;

  // overflow action encodings
  localparam logic ACT_NMI = 1'b0;
  localparam logic ACT_RESET = 1'b1;

  // timing counts in clock cycles (125 MHz)
  localparam int CNT_W = 26;
  localparam logic [5:0] RESET_HOLD_CYCLES = 6'h20;
  localparam logic [1:0] LOCK_CYCLES = 2'h2;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rwdt_bus_req_s;

  // outputs towards the interrupt and reset logic and the pin
  typedef struct packed {
    logic timeout_interrupt;
    logic timeout_out_n;
    logic chip_reset_req;
  } rwdt_evt_s;

  // whole state of the watchdog core
  typedef struct packed {
    logic en;
    logic [2:0] period;
    logic rsv;
    logic zero;
    logic action;
    logic run;
    logic [CNT_W-1:0] cnt;
    logic out_n;
    logic nmi;
    logic [5:0] rst_cnt;
    logic [1:0] lock_cnt;
    logic lock_mode;
    logic [31:0] rdata;
  } rwdt_state_s;

  // state of a two-stage synchroniser
  typedef struct packed {
    logic meta;
    logic sync;
  } rwdt_sync_s;

endpackage

/* logic/rwdt_sync.sv */
// two flip-flop synchroniser for a level from outside the clock domain
module rwdt_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // level in and out
  input wire logic async_in,
  output logic sync_out
);
  import rwdt_pkg::*;

  rwdt_sync_s state_q;
  rwdt_sync_s state_d;

  // the first stage feeds only the second stage
  always_comb begin
    state_d = state_q;
    state_d.meta = async_in;
    state_d.sync = state_q.meta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.sync;

endmodule

/* logic/rwdt_top.sv */
// runaway watchdog timer: register slave, binary counter, overflow response
// Summary of operation
// - flag bit 0 reads 1 while mode or command writes are refused, else 0
// - timeout is a binary up-counter stepped by the system clock
// - three-bit period select picks 2^15 to 2^25 cycles in steps of two
// - on expiry drive the output pin low and raise the timeout interrupt or the chip reset request
// - action 0: overflow gives an interrupt request and pin low together
// - clear code 0x4E returns the output pin high
// - action 1: overflow requests chip reset held for 32 clock cycles
// - counting starts right after reset with no software action
// - counter holds while the processor is in debug mode
// - disable: clear enable, then write 0xB1; stops and clears the counter
// - mode then command writes back to back are accepted for disabling
// - clear code 0x4E zeroes the counter and counting restarts at once
// - period code 011 means 2^21 cycles
// - codes 000..101 give 2^15..2^25; 110 and 111 are reserved
// - action bit selects interrupt (0) or chip reset (1); resets to 1
// - setting enable to 1 restarts a disabled watchdog; enable resets to 1
module rwdt_top #(
  parameter int unsigned EXP_BASE = rwdt_pkg::PER_EXP_BASE
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register bus
  input rwdt_pkg::rwdt_bus_req_s bus_req,
  output logic [31:0] bus_rdata,
  // debug status from the processor, asynchronous
  input wire logic debug_mode,
  // overflow responses
  output rwdt_pkg::rwdt_evt_s evt
);
  import rwdt_pkg::*;

  rwdt_state_s state_q;
  rwdt_state_s state_d;
  logic dbg_sync;

  // bus decode
  logic sel_mode;
  logic sel_cmd;
  logic sel_flag;
  logic locked;
  logic wr_mode_ok;
  logic wr_cmd_ok;
  logic [7:0] cmd_code;
  logic cmd_clear;
  logic cmd_disable;

  // counter decode
  logic [2:0] per_code;
  logic [5:0] per_exp;
  logic [CNT_W-1:0] per_last;
  logic counting;
  logic expire;
  logic [31:0] rd_value;

  rwdt_sync u_dbg_sync (
    .clock(clock),
    .rst(rst),
    .async_in(debug_mode),
    .sync_out(dbg_sync)
  );

  // address decode of the three words
  assign sel_mode = (bus_req.addr == OFS_MODE);
  assign sel_cmd = (bus_req.addr == OFS_CMD);
  assign sel_flag = (bus_req.addr == OFS_FLAG);

  // a write reaches the counter at the next edge, then blocks further writes for two cycles, except commands after a mode write
  assign locked = (state_q.lock_cnt != 2'h0);

  // mode writes need a clear flag; a command write may chase a mode write
  assign wr_mode_ok = bus_req.wr && sel_mode && !locked;
  assign wr_cmd_ok = bus_req.wr && sel_cmd && (!locked || state_q.lock_mode);

  // command decode, any other value only starts the lock countdown
  assign cmd_code = bus_req.wdata[7:0];
  assign cmd_clear = wr_cmd_ok && (cmd_code == CODE_CLEAR);
  assign cmd_disable = wr_cmd_ok && (cmd_code == CODE_DISABLE) && !state_q.en;

  // reserved period codes run at the longest period rather than at random
  assign per_code = (state_q.period > PER_MAX_CODE) ? PER_MAX_CODE : state_q.period;

  // exponent is base plus two per code step, 011 lands on 2^21
  assign per_exp = 6'(EXP_BASE) + (PER_EXP_STEP * {3'h0, per_code});
  assign per_last = (CNT_W'(1) << per_exp) - CNT_W'(1);

  // counter runs from reset, frozen under debug
  assign counting = state_q.run && !dbg_sync;
  assign expire = counting && (state_q.cnt == per_last);

  // read mux, unused bits read as zero
  always_comb begin
    rd_value = 32'h0000_0000;
    if (sel_mode) begin
      rd_value[MODE_EN_BIT] = state_q.en;
      rd_value[MODE_PER_MSB:MODE_PER_LSB] = state_q.period;
      rd_value[MODE_RSV_BIT] = state_q.rsv;
      rd_value[MODE_ACT_BIT] = state_q.action;
      rd_value[MODE_ZERO_BIT] = state_q.zero;
    end else if (sel_flag) begin
      rd_value[FLAG_LOCK_BIT] = locked;
    end
  end

  // next state
  always_comb begin
    state_d = state_q;

    // one-cycle interrupt request drops by default
    state_d.nmi = 1'b0;

    // read data only in the cycle after the strobe
    state_d.rdata = bus_req.rd ? rd_value : 32'h0000_0000;

    // lock countdown
    if (state_q.lock_cnt != 2'h0) begin
      state_d.lock_cnt = state_q.lock_cnt - 2'h1;
    end
    if (state_q.lock_cnt == 2'h1) begin
      state_d.lock_mode = 1'b0;
    end

    // mode register write
    if (wr_mode_ok) begin
      state_d.en = bus_req.wdata[MODE_EN_BIT];
      state_d.period = bus_req.wdata[MODE_PER_MSB:MODE_PER_LSB];
      state_d.rsv = bus_req.wdata[MODE_RSV_BIT];
      state_d.zero = bus_req.wdata[MODE_ZERO_BIT];
      state_d.action = bus_req.wdata[MODE_ACT_BIT];
      state_d.lock_cnt = LOCK_CYCLES;
      state_d.lock_mode = 1'b1;
      if (bus_req.wdata[MODE_EN_BIT]) begin
        state_d.run = 1'b1;
      end
    end

    // command write of any value occupies the transfer path
    if (wr_cmd_ok) begin
      state_d.lock_cnt = LOCK_CYCLES;
      state_d.lock_mode = 1'b0;
    end

    // binary up-counter
    if (counting) begin
      state_d.cnt = state_q.cnt + CNT_W'(1);
    end

    // overflow wraps the counter and triggers the chosen response
    if (expire) begin
      state_d.cnt = '0;
      state_d.out_n = 1'b0;
      if (state_q.action == ACT_NMI) begin
        state_d.nmi = 1'b1;
      end else begin
        state_d.rst_cnt = RESET_HOLD_CYCLES;
      end
    end else if (state_q.rst_cnt != 6'h00) begin
      state_d.rst_cnt = state_q.rst_cnt - 6'h01;
    end

    // clear code restarts the count; a same-cycle overflow still drops the pin
    if (cmd_clear) begin
      state_d.cnt = '0;
      if (!expire) begin
        state_d.out_n = 1'b1;
      end
    end

    // disable only after enable was already cleared
    if (cmd_disable) begin
      state_d.run = 1'b0;
      state_d.cnt = '0;
    end
  end

  // registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= '0;
      state_q.en <= RST_EN;
      state_q.period <= RST_PER;
      state_q.rsv <= RST_RSV;
      state_q.zero <= RST_ZERO;
      state_q.action <= RST_ACT;
      state_q.run <= 1'b1;
      state_q.out_n <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs straight from flip-flops, chip reset request decoded from the hold count
  assign bus_rdata = state_q.rdata;
  assign evt.timeout_interrupt = state_q.nmi;
  assign evt.timeout_out_n = state_q.out_n;
  assign evt.chip_reset_req = (state_q.rst_cnt != 6'h00);

endmodule

/* tb/rwdt_asserts.sv */
// port assertions for the runaway watchdog
module rwdt_asserts import rwdt_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // watched ports
  input rwdt_pkg::rwdt_bus_req_s bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic debug_mode,
  input rwdt_pkg::rwdt_evt_s evt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] hold_q;
  logic clr;
  assign clr = bus_req.wr && bus_req.addr == OFS_CMD && bus_req.wdata[7:0] == CODE_CLEAR;
  always_ff @(posedge clock) begin
    hold_q <= (rst || !evt.chip_reset_req) ? 7'h00 : hold_q + 7'h01;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside read cycle");
  a_flag_upper: assert property ($past(bus_req.rd) && $past(bus_req.addr) == OFS_FLAG
    |-> bus_rdata[31:1] == 31'h0) else $error("flag upper bits set");
  // no write in the last two cycles means the lock is open
  a_clear_pin: assert property (clr && !$past(bus_req.wr) && !$past(bus_req.wr, 2)
    && !evt.timeout_out_n && !evt.timeout_interrupt |=> evt.timeout_out_n)
    else $error("pin not raised by clear");
  a_pin_holds: assert property (!evt.timeout_out_n && !clr |=> !evt.timeout_out_n)
    else $error("pin rose without clear");
  a_pin_cause: assert property ($fell(evt.timeout_out_n)
    |-> evt.timeout_interrupt || evt.chip_reset_req) else $error("pin low without event");
  a_irq_pulse: assert property (evt.timeout_interrupt |=> !evt.timeout_interrupt)
    else $error("interrupt longer than one cycle");
  a_reset_len: assert property ($fell(evt.chip_reset_req) |-> hold_q == 7'h20)
    else $error("chip reset length wrong");
  a_reset_bound: assert property (hold_q <= 7'h20)
    else $error("chip reset too long");
endmodule

bind rwdt_top rwdt_asserts u_chk (.clock(clock), .rst(rst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .debug_mode(debug_mode), .evt(evt));

/* tb/rwdt_evt_model.sv */
// far side model: interrupt intake and chip reset logic
module rwdt_evt_model import rwdt_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // requests from the watchdog
  input rwdt_pkg::rwdt_evt_s evt,
  // observations for the bench
  output int nmi_cnt,
  output int rst_len
);
  timeunit 1ns;
  timeprecision 1ps;
  int run;
  always @(posedge clock) begin
    if (rst) begin
      nmi_cnt <= 0;
      run <= 0;
      rst_len <= 0;
    end else begin
      if (evt.timeout_interrupt)
        nmi_cnt <= nmi_cnt + 1;
      if (evt.chip_reset_req)
        run <= run + 1;
      else if (run != 0) begin
        rst_len <= run;
        run <= 0;
      end
    end
  end
endmodule

/* tb/tb.sv */
// testbench for the runaway watchdog
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rwdt_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic debug_mode = 1'b0;
  rwdt_bus_req_s bus_req = '0;
  logic [31:0] bus_rdata;
  rwdt_evt_s evt;
  int nmi_cnt, rst_len, k, cyc = 0, n_errors = 0, samples_checked = 0;
  // short base exponent keeps the longest period at 8192 cycles
  rwdt_top #(.EXP_BASE(3)) uut (.clock(clock), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .debug_mode(debug_mode), .evt(evt));
  rwdt_evt_model far (.clock(clock), .rst(rst), .evt(evt), .nmi_cnt(nmi_cnt),
    .rst_len(rst_len));
  initial forever #4 clock = ~clock;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge clock);
  endtask
  task automatic nop;
    bus(1'b0, 1'b0, 8'h00, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, 1'b1, a, 32'h0);
    nop();
    chk("read data", exp, bus_rdata);
  endtask
  // counts edges from the last write until an overflow event shows
  task automatic period(input int exp);
    int n;
    n = 0;
    nop();
    while (n < 9000 && evt.timeout_interrupt !== 1'b1 && evt.chip_reset_req !== 1'b1) begin
      @(posedge clock);
      n++;
    end
    if (exp != 0)
      chk("cycles to expiry", exp, n);
    chk("output pin", 32'h0, {31'h0, evt.timeout_out_n});
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(OFS_MODE, 32'h82);
    wr(OFS_MODE, 32'hB2);
    rd(OFS_FLAG, 32'h1);
    rd(OFS_FLAG, 32'h0);
    rd(OFS_CMD, 32'h0);
    rd(8'h0C, 32'h0);
    period(0);
    repeat (40) @(posedge clock);
    chk("reset length", 32'h20, rst_len);
    wr(OFS_CMD, 32'h4E);
    wr(OFS_MODE, 32'h0);
    rd(OFS_MODE, 32'hB2);
    chk("pin after clear", 32'h1, {31'h0, evt.timeout_out_n});
    for (k = 0; k < 7; k++) begin
      wr(OFS_MODE, {24'h0, 1'b1, 3'(k), 4'h0});
      wr(OFS_CMD, {24'h0, CODE_CLEAR});
      period(1 << (3 + 2 * (k > 5 ? 5 : k)));
    end
    wr(OFS_MODE, 32'h0);
    wr(OFS_CMD, {24'h0, CODE_DISABLE});
    nop();
    // let the disable settle so the odd code is taken, not refused
    nop();
    wr(OFS_CMD, 32'h12);
    rd(OFS_FLAG, 32'h1);
    repeat (100) @(posedge clock);
    chk("interrupt count", 32'h7, nmi_cnt);
    wr(OFS_MODE, 32'h80);
    wr(OFS_CMD, {24'h0, CODE_CLEAR});
    period(8);
    debug_mode <= 1'b1;
    wr(OFS_CMD, {24'h0, CODE_CLEAR});
    nop();
    repeat (50) @(posedge clock);
    chk("interrupts in debug", 32'h8, nmi_cnt);
    debug_mode <= 1'b0;
    period(0);
    stop_test();
  end
endmodule
